// [src/sfp_map.svh]
// constants of the short-float pack/unpack processing element
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
// 40-bit register field positions
`define SFP_REG_SIGN 39
`define SFP_REG_EXP_HI 38
`define SFP_REG_EXP_LO 31
`define SFP_REG_FRAC_HI 30
`define SFP_REG_FRAC_LO 8
`define SFP_REG_XFRAC_LO 0
`define SFP_SHORT_HI 23
`define SFP_SHORT_LO 8
// exponent codes
`define SFP_EXP_BIAS 8'h7F
`define SFP_EXP_ALL1 8'hFF
`define SFP_PACK_MAX_EXP 8'h87
`define SFP_PACK_NORM_MIN 8'h79
`define SFP_PACK_DEN_TOP 8'h78
`define SFP_PACK_DEN_MIN 8'h6E
`define SFP_UNPACK_DEN_BASE 8'h78
`define SFP_SHORT_LARGEST 15'h7FFF
`define SFP_UNPACK_PAD 12'h000
// reset values
`define SFP_FLAG_RST 1'b0
`define SFP_REG_RST 40'h00_0000_0000
`endif

// [src/sfp_pkg.sv]
// types shared by the short-float processing element files
package sfp_pkg;
  typedef enum logic [3:0] {
    SFP_OP_NOP = 4'h0,
    SFP_OP_FPACK = 4'h1,
    SFP_OP_FUNPACK = 4'h2,
    SFP_OP_LSH = 4'h3,
    SFP_OP_ASH = 4'h4,
    SFP_OP_BCLR = 4'h5,
    SFP_OP_BSET = 4'h6,
    SFP_OP_BTGL = 4'h7,
    SFP_OP_FDEP = 4'h8,
    SFP_OP_FEXT = 4'h9,
    SFP_OP_EXP = 4'hA
  } sfp_op_t;
  typedef enum logic [2:0] {
    SFP_CL_ZERO = 3'h0,
    SFP_CL_DENORM = 3'h1,
    SFP_CL_NORMAL = 3'h3,
    SFP_CL_INF = 3'h2,
    SFP_CL_NAN = 3'h6
  } sfp_fclass_t;
endpackage : sfp_pkg

// [src/sfp_conv_if.sv]
// carrier between the core and the pack/unpack converter
`timescale 1ns/1ps
interface sfp_conv_if;
  logic [39:0] x;
  logic [39:0] packRes;
  logic packOvf;
  logic [39:0] unpackRes;
  modport unit (input x, output packRes, output packOvf, output unpackRes);
  modport core (output x, input packRes, input packOvf, input unpackRes);
endinterface : sfp_conv_if

// [src/sfp_conv.sv]
// combinational float-to-short-float pack and short-float-to-float unpack
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_conv (
  // operand and results
  sfp_conv_if.unit cv
);
  import sfp_pkg::*;

  function automatic logic [3:0] lzc11(input logic [10:0] v);
    logic [3:0] n;
    logic hit;
    n = 4'hB;
    hit = 1'b0;
    for (int i = 10; i >= 0; i--) begin
      if (v[i] && !hit) begin
        n = 4'(10 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction : lzc11

  // pack side
  logic sSign;
  logic [7:0] sExp;
  logic [22:0] sFrac;
  logic huge, normRange, denRange, guard, sticky, inc, rndOvf;
  logic [3:0] shr;
  logic [34:0] denShift;
  logic [14:0] base;
  logic [15:0] sum;
  logic [15:0] packed16;
  assign sSign = cv.x[`SFP_REG_SIGN];
  assign sExp = cv.x[`SFP_REG_EXP_HI:`SFP_REG_EXP_LO];
  assign sFrac = cv.x[`SFP_REG_FRAC_HI:`SFP_REG_FRAC_LO];
  assign huge = sExp > `SFP_PACK_MAX_EXP; // RL10
  assign normRange = sExp >= `SFP_PACK_NORM_MIN;
  assign denRange = sExp >= `SFP_PACK_DEN_MIN;
  // gradual underflow: hidden one shifted right by 120 - exponent
  assign shr = 4'(`SFP_PACK_DEN_TOP - sExp); // RL12
  assign denShift = {1'b1, sFrac, 11'h000} >> shr; // RL12
  assign base = normRange ? {sExp[7], sExp[2:0], sFrac[22:12]} // RL10 RL11
                          : {4'h0, denShift[34:24]}; // RL12
  assign guard = normRange ? sFrac[11] : denShift[23];
  assign sticky = normRange ? |sFrac[10:0] : |denShift[22:0];
  // round to nearest even; a carry may move a denormal up to exponent one
  assign inc = guard & (sticky | base[0]); // RL11 RL12
  assign sum = {1'b0, base} + {15'h0000, inc};
  assign rndOvf = normRange & sum[15];
  assign cv.packOvf = huge | rndOvf; // RL17
  assign packed16 = cv.packOvf ? {sSign, `SFP_SHORT_LARGEST} // RL10 RL14
                  : denRange ? {sSign, sum[14:0]} // RL14
                  : 16'h0000; // RL13
  assign cv.packRes = {16'h0000, packed16, 8'h00}; // RL9 RL22

  // unpack side
  logic uSign;
  logic [3:0] uExp;
  logic [10:0] uFrac;
  logic [3:0] nLead;
  logic [11:0] normFrac;
  logic [7:0] outExp;
  logic [22:0] outFrac;
  assign uSign = cv.x[`SFP_SHORT_HI];
  assign uExp = cv.x[22:19];
  assign uFrac = cv.x[18:`SFP_SHORT_LO];
  assign nLead = lzc11(uFrac);
  assign normFrac = {1'b0, uFrac} << (nLead + 4'h1); // RL16
  assign outExp = (uExp != 4'h0) ? {{4{~uExp[3]}}, uExp} // RL15
                : (uFrac == 11'h000) ? 8'h00 // RL23
                : `SFP_UNPACK_DEN_BASE - {4'h0, nLead}; // RL16
  assign outFrac = (uExp != 4'h0) ? {uFrac, `SFP_UNPACK_PAD} // RL15
                                  : {normFrac[10:0], `SFP_UNPACK_PAD}; // RL16
  assign cv.unpackRes = {uSign, outExp, outFrac, 8'h00}; // RL14
endmodule : sfp_conv

// [src/sfp_core.sv]
// processing element: register file, shifter with float pack/unpack, format decode
// Function
// RL1: every computation completes in one cycle
// RL2: ten-port file, sixteen primary, sixteen alternate
// RL3: result usable as operand next cycle
// RL4: single float: sign, 8-bit exponent, 23-bit fraction
// RL5: exponents 1 to 254 normal, bias 127
// RL6: exponent 255 is NaN or infinity
// RL7: zero and infinity carry either sign
// RL8: extended 40-bit float has 32-bit significand
// RL9: short float: sign, 4-bit exponent, 11-bit mantissa
// RL10: pack saturates above 135, else exponent remap
// RL11: normal pack rounds upper eleven fraction bits
// RL12: pack 110 to 120 yields rounded denormal
// RL13: pack below 110 gives all zeros
// RL14: pack and unpack keep the sign
// RL15: unpack normal: exponent widened, twelve zeros appended
// RL16: unpack denormal: exponent 120 minus leading zeros
// RL17: pack sets overflow flag, unpack clears it
// RL18: pack and unpack clear zero, sign flags
// RL19: pack and unpack take one cycle
// RL20: fixed point is 32-bit, fraction or integer
// RL21: shifter shifts, edits bits, fields, derives exponents
// RL22: short float sits in register bits 23:8
// RL23: unpacking all-zero short float gives signed zero
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_core #(
  parameter int NREG = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bank mode
  input wire logic altBank,
  // shifter instruction
  input wire logic opValid,
  input wire sfp_pkg::sfp_op_t opCode,
  input wire logic [3:0] srcX,
  input wire logic [3:0] srcY,
  input wire logic [3:0] dst,
  // other computational units
  input wire logic [3:0] extRdAddrA,
  output logic [39:0] extRdDataA,
  input wire logic [3:0] extRdAddrB,
  output logic [39:0] extRdDataB,
  input wire logic extWrEn,
  input wire logic [3:0] extWrAddr,
  input wire logic [39:0] extWrData,
  // program_memory_bus port
  input wire logic pmWrEn,
  input wire logic [3:0] pmAddr,
  input wire logic [39:0] pmWrData,
  output logic [39:0] pmRdData,
  // data_memory_bus port
  input wire logic dmWrEn,
  input wire logic [3:0] dmAddr,
  input wire logic [39:0] dmWrData,
  output logic [39:0] dmRdData,
  // shifter condition flags
  output logic shifterOverflowFlag,
  output logic shifterZeroFlag,
  output logic shifterSignFlag,
  // format decode of operand x
  output sfp_pkg::sfp_fclass_t xClass,
  output logic xSign,
  output logic signed [8:0] xTrueExp,
  output logic [31:0] xSignificand
);
  import sfp_pkg::*;

  // sixteen primary plus sixteen alternate registers
  logic [39:0] rf_q [0:2*NREG-1]; // RL2
  logic [39:0] pmRd_q, dmRd_q;
  logic ovf_q, zero_q, sign_q;
  sfp_fclass_t cls_q;
  logic clsSign_q;
  logic signed [8:0] trueExp_q;
  logic [31:0] signif_q;

  // bank select prepends one address bit on every port
  logic [4:0] xIdx, yIdx, dIdx, aIdx, bIdx, eIdx, pIdx, mIdx;
  assign xIdx = {altBank, srcX}; // RL2
  assign yIdx = {altBank, srcY};
  assign dIdx = {altBank, dst};
  assign aIdx = {altBank, extRdAddrA};
  assign bIdx = {altBank, extRdAddrB};
  assign eIdx = {altBank, extWrAddr};
  assign pIdx = {altBank, pmAddr};
  assign mIdx = {altBank, dmAddr};

  logic [39:0] xReg, yReg;
  assign xReg = rf_q[xIdx];
  assign yReg = rf_q[yIdx];
  // operand reads are straight from the array so last cycle's write is seen
  assign extRdDataA = rf_q[aIdx]; // RL3
  assign extRdDataB = rf_q[bIdx]; // RL3

  sfp_conv_if cif ();
  assign cif.x = xReg;
  sfp_conv u_conv (
    .cv(cif)
  );

  // fixed-point view: upper 32 bits, low byte ignored
  logic [31:0] xv, yv;
  assign xv = xReg[39:8]; // RL20
  assign yv = yReg[39:8];

  function automatic logic [4:0] redundantSigns(input logic [31:0] v);
    logic [4:0] n;
    logic stop;
    n = 5'h00;
    stop = 1'b0;
    for (int i = 30; i >= 0; i--) begin
      if (!stop && (v[i] == v[31])) begin
        n = n + 5'h01;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction : redundantSigns

  // shift amount is a signed byte; positive moves left
  logic signed [7:0] sAmt;
  logic [7:0] sMag;
  logic sOut;
  logic [31:0] lshRes, ashRes, bitMask, fMask, fextRes, fdepRes, expRes;
  logic lshLost;
  logic [4:0] fPos;
  logic [5:0] fLen;
  assign sAmt = yv[7:0];
  assign sMag = sAmt[7] ? 8'(-sAmt) : sAmt;
  assign sOut = sMag >= 8'h20;
  assign lshRes = sOut ? 32'h0000_0000 // RL21
                : sAmt[7] ? (xv >> sMag[4:0]) : (xv << sMag[4:0]);
  assign ashRes = !sAmt[7] ? lshRes // RL21
                : sOut ? {32{xv[31]}} : 32'($signed(xv) >>> sMag[4:0]);
  // left shifts that drop set bits report overflow
  assign lshLost = !sAmt[7] && (sOut ? (xv != 32'h0000_0000)
                                     : ((lshRes >> sMag[4:0]) != xv));
  assign bitMask = 32'h0000_0001 << yv[4:0]; // RL21
  assign fPos = yv[4:0];
  assign fLen = yv[11:6];
  assign fMask = (fLen >= 6'h20) ? 32'hFFFF_FFFF
               : ((32'h0000_0001 << fLen[4:0]) - 32'h0000_0001);
  assign fextRes = (xv >> fPos) & fMask; // RL21
  assign fdepRes = (xv & fMask) << fPos; // RL21
  assign expRes = 32'(-{27'h000_0000, redundantSigns(xv)}); // RL21

  logic [39:0] shRes;
  logic shOvf, shZero, shSign;
  always_comb begin
    shRes = 40'h00_0000_0000;
    shOvf = 1'b0;
    case (opCode)
      SFP_OP_FPACK: begin
        shRes = cif.packRes; // RL19
        shOvf = cif.packOvf; // RL17
      end
      SFP_OP_FUNPACK: begin
        shRes = cif.unpackRes; // RL19
        shOvf = 1'b0; // RL17
      end
      SFP_OP_LSH: begin
        shRes = {lshRes, 8'h00};
        shOvf = lshLost;
      end
      SFP_OP_ASH: begin
        shRes = {ashRes, 8'h00};
        shOvf = lshLost;
      end
      SFP_OP_BCLR: shRes = {xv & ~bitMask, 8'h00};
      SFP_OP_BSET: shRes = {xv | bitMask, 8'h00};
      SFP_OP_BTGL: shRes = {xv ^ bitMask, 8'h00};
      SFP_OP_FDEP: shRes = {fdepRes, 8'h00};
      SFP_OP_FEXT: shRes = {fextRes, 8'h00};
      SFP_OP_EXP: shRes = {expRes, 8'h00};
      default: shRes = 40'h00_0000_0000;
    endcase
  end
  // conversions clear zero and sign regardless of the value produced
  logic isConv, doOp;
  assign isConv = (opCode == SFP_OP_FPACK) || (opCode == SFP_OP_FUNPACK);
  assign doOp = opValid && (opCode != SFP_OP_NOP);
  assign shZero = !isConv && (shRes[39:8] == 32'h0000_0000); // RL18
  assign shSign = !isConv && shRes[39]; // RL18

  // write priority: shifter over other units over data bus over program bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2 * NREG; i++) begin
        rf_q[i] <= `SFP_REG_RST;
      end
    end else begin
      if (pmWrEn) begin
        rf_q[pIdx] <= pmWrData;
      end
      if (dmWrEn) begin
        rf_q[mIdx] <= dmWrData;
      end
      if (extWrEn) begin
        rf_q[eIdx] <= extWrData;
      end
      if (doOp) begin
        rf_q[dIdx] <= shRes; // RL1 RL19
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmRd_q <= `SFP_REG_RST;
      dmRd_q <= `SFP_REG_RST;
    end else begin
      pmRd_q <= rf_q[pIdx];
      dmRd_q <= rf_q[mIdx];
    end
  end
  assign pmRdData = pmRd_q;
  assign dmRdData = dmRd_q;

  // flags change only when an operation issues
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= `SFP_FLAG_RST;
      zero_q <= `SFP_FLAG_RST;
      sign_q <= `SFP_FLAG_RST;
    end else if (doOp) begin
      ovf_q <= shOvf; // RL17
      zero_q <= shZero; // RL18
      sign_q <= shSign; // RL18
    end
  end
  assign shifterOverflowFlag = ovf_q;
  assign shifterZeroFlag = zero_q;
  assign shifterSignFlag = sign_q;

  // format decode of operand x, 40-bit extended view
  logic [7:0] dExp;
  logic [30:0] dFrac;
  sfp_fclass_t dCls;
  assign dExp = xReg[`SFP_REG_EXP_HI:`SFP_REG_EXP_LO]; // RL4
  assign dFrac = xReg[`SFP_REG_FRAC_HI:`SFP_REG_XFRAC_LO]; // RL8
  assign dCls = (dExp == `SFP_EXP_ALL1) ? ((dFrac != 31'h0) ? SFP_CL_NAN : SFP_CL_INF) // RL6
              : (dExp != 8'h00) ? SFP_CL_NORMAL // RL5
              : (dFrac == 31'h0) ? SFP_CL_ZERO : SFP_CL_DENORM; // RL6
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cls_q <= SFP_CL_ZERO;
      clsSign_q <= 1'b0;
      trueExp_q <= 9'sh000;
      signif_q <= 32'h0000_0000;
    end else begin
      cls_q <= dCls;
      clsSign_q <= xReg[`SFP_REG_SIGN]; // RL7
      trueExp_q <= $signed({1'b0, dExp}) - $signed({1'b0, `SFP_EXP_BIAS}); // RL5
      signif_q <= {(dExp != 8'h00), dFrac}; // RL4 RL8
    end
  end
  assign xClass = cls_q;
  assign xSign = clsSign_q;
  assign xTrueExp = trueExp_q;
  assign xSignificand = signif_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic pack, unpack;
  assign pack = doOp && (opCode == SFP_OP_FPACK);
  assign unpack = doOp && (opCode == SFP_OP_FUNPACK);

  AST_ONE_CYCLE: assert property (doOp |=> rf_q[$past(dIdx)] == $past(shRes)) // RL1
    else $error("result not written one cycle after issue");
  AST_FORWARD: assert property ((doOp ##1 (aIdx == $past(dIdx))) // RL3
      |-> extRdDataA == $past(shRes))
    else $error("result not usable as operand next cycle");
  AST_PACK_HUGE: assert property ((pack && xReg[38:31] > 8'h87) |=> // RL10
      rf_q[$past(dIdx)][22:8] == 15'h7FFF && ovf_q)
    else $error("pack above range did not saturate");
  AST_PACK_NORM_EXP: assert property ((pack && xReg[38:31] >= 8'h79 && // RL10
      xReg[38:31] <= 8'h86) |-> cif.packRes[22:19] ==
      4'({xReg[38], xReg[33:31]} + {3'h0, cif.packRes[22:19] != {xReg[38], xReg[33:31]}}))
    else $error("pack exponent remap wrong");
  AST_PACK_DENORM: assert property ((pack && xReg[38:31] >= 8'h6E && // RL12
      xReg[38:31] <= 8'h77) |-> cif.packRes[22:19] == 4'h0 && cif.packRes[18:8] != 11'h000)
    else $error("underflow pack not a denormal");
  AST_PACK_ZERO: assert property ((pack && xReg[38:31] < 8'h6E) |=> // RL13
      rf_q[$past(dIdx)] == 40'h00_0000_0000)
    else $error("pack below range not all zeros");
  AST_SIGN: assert property ((pack && xReg[38:31] >= 8'h6E) || unpack |-> // RL14
      (pack ? cif.packRes[23] : cif.unpackRes[39]) == (pack ? xReg[39] : xReg[23]))
    else $error("sign not carried through conversion");
  AST_UNPACK_NORM: assert property ((unpack && xReg[22:19] != 4'h0) |-> // RL15
      cif.unpackRes[38:31] == {{4{~xReg[22]}}, xReg[22:19]} && cif.unpackRes[19:8] == 12'h000)
    else $error("unpack of normal short float wrong");
  AST_UNPACK_DEN: assert property ((unpack && xReg[22:19] == 4'h0 && xReg[18]) |-> // RL16
      cif.unpackRes[38:31] == 8'h78 && cif.unpackRes[30:20] == {xReg[17:8], 1'b0})
    else $error("unpack of denormal short float wrong");
  AST_UNPACK_ZERO: assert property ((unpack && xReg[22:8] == 15'h0000) |-> // RL23
      cif.unpackRes[38:0] == 39'h00_0000_0000)
    else $error("unpack of zero not a signed zero");
  AST_CONV_FLAGS: assert property ((unpack || pack) |=> // RL17
      !zero_q && !sign_q && (ovf_q == ($past(pack) && $past(cif.packOvf))))
    else $error("conversion flags wrong");
  AST_CLASS: assert property ((xReg[38:31] == 8'hFF) |=> // RL6
      (cls_q == SFP_CL_NAN) == ($past(xReg[30:0]) != 31'h0) && cls_q != SFP_CL_NORMAL)
    else $error("all-ones exponent misclassified");

  COV_PACK_OVF: cover property (pack && cif.packOvf);
  COV_PACK_DEN: cover property (pack && xReg[38:31] == 8'h70);
  COV_UNPACK_DEN: cover property (unpack && xReg[22:19] == 4'h0 && xReg[18:8] != 11'h000);
  COV_CHAIN: cover property (pack ##1 (unpack && xIdx == $past(dIdx)));
endmodule : sfp_core

// [test/tb_top.sv]
// self-checking bench for the short-float processing element core
`timescale 1ns/1ps
module tb_top;
  import sfp_pkg::*;
  typedef struct {
    logic [1:0] sel;
    logic [47:0] v;
    logic [47:0] m;
  } sfp_note_t;
  localparam logic [47:0] ALL = 48'hFFFF_FFFF_FFFF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic altBank, opValid, extWrEn, pmWrEn, dmWrEn;
  sfp_op_t opCode;
  logic [3:0] srcX, srcY, dst, extRdAddrA, extRdAddrB, extWrAddr, pmAddr, dmAddr;
  logic [39:0] extWrData, pmWrData, dmWrData, extRdDataA, extRdDataB, pmRdData, dmRdData;
  logic shifterOverflowFlag, shifterZeroFlag, shifterSignFlag, xSign;
  sfp_fclass_t xClass;
  logic signed [8:0] xTrueExp;
  logic [31:0] xSignificand;
  sfp_note_t notes[$];
  sfp_note_t nt;
  logic [47:0] obs;
  int fails = 0;
  int n_checks = 0;
  logic [31:0] dirF [8] = '{32'h43FF_FFFF, 32'h4400_0000, 32'hC100_0800, 32'h3C80_1800,
    32'hBC7F_F000, 32'h3740_0000, 32'hB6FF_FFFF, 32'h3F80_0000};
  logic [31:0] decF [5] = '{32'hFF80_0000, 32'h7FC0_0000, 32'h8000_0000, 32'h3F80_0000,
    32'h0040_0000};
  logic [15:0] dirH [6] = '{16'h8000, 16'h0001, 16'h0400, 16'hFFFF, 16'h0800, 16'h7BFF};

  always #2 clk = ~clk;

  sfp_core #(.NREG(16)) u_dut (
    .clk(clk), .rst_n(rst_n), .altBank(altBank), .opValid(opValid), .opCode(opCode),
    .srcX(srcX), .srcY(srcY), .dst(dst),
    .extRdAddrA(extRdAddrA), .extRdDataA(extRdDataA),
    .extRdAddrB(extRdAddrB), .extRdDataB(extRdDataB),
    .extWrEn(extWrEn), .extWrAddr(extWrAddr), .extWrData(extWrData),
    .pmWrEn(pmWrEn), .pmAddr(pmAddr), .pmWrData(pmWrData), .pmRdData(pmRdData),
    .dmWrEn(dmWrEn), .dmAddr(dmAddr), .dmWrData(dmWrData), .dmRdData(dmRdData),
    .shifterOverflowFlag(shifterOverflowFlag), .shifterZeroFlag(shifterZeroFlag),
    .shifterSignFlag(shifterSignFlag), .xClass(xClass), .xSign(xSign),
    .xTrueExp(xTrueExp), .xSignificand(xSignificand)
  );

  // reference pack: {overflow, short float}, round to nearest even
  function automatic logic [16:0] packRef(input logic [31:0] f);
    logic [7:0] e;
    logic [47:0] w;
    logic [15:0] t;
    logic inc;
    e = f[30:23];
    if (e > 8'h87) return {1'b1, f[31], 15'h7FFF};
    if (e < 8'h6E) return 17'h00000;
    if (e > 8'h78) w = {f[22:0], 25'h0};
    else w = {1'b1, f[22:0], 24'h0} >> (8'h78 - e);
    inc = w[36] & ((|w[35:0]) | w[37]);
    // a rounding carry ripples into the exponent field, past 15 it saturates
    t = {1'b0, (e > 8'h78) ? {e[7], e[2:0]} : 4'h0, w[47:37]} + 16'(inc);
    if (t[15]) return {1'b1, f[31], 15'h7FFF};
    return {1'b0, f[31], t[14:0]};
  endfunction : packRef

  function automatic logic [31:0] unpackRef(input logic [15:0] h);
    int n;
    logic [10:0] m;
    m = h[10:0];
    if (h[14:11] != 4'h0) return {h[15], {4{~h[14]}}, h[14:11], m, 12'h000};
    if (m == 11'h000) return {h[15], 31'h0};
    n = 0;
    while (!m[10]) begin
      m = m << 1;
      n++;
    end
    return {h[15], 8'(8'h78 - n), m[9:0], 13'h0000};
  endfunction : unpackRef

  function automatic logic [47:0] decRef(input logic [39:0] d);
    logic [7:0] e;
    logic fz;
    sfp_fclass_t cl;
    e = d[38:31];
    fz = (d[30:0] == 31'h0);
    if (e == 8'hFF) cl = fz ? SFP_CL_INF : SFP_CL_NAN;
    else if (e == 8'h00) cl = fz ? SFP_CL_ZERO : SFP_CL_DENORM;
    else cl = SFP_CL_NORMAL;
    return {3'h0, cl, d[39], 9'(e) - 9'h07F, 1'b1, d[30:0]};
  endfunction : decRef

  task automatic push(input logic [1:0] sel, input logic [47:0] v, input logic [47:0] m);
    notes.push_back('{sel, v, m});
  endtask : push

  // every note pushed at a falling edge is judged at the next rising edge
  always @(posedge clk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt.sel)
        2'h0: obs = {5'h00, shifterOverflowFlag, shifterZeroFlag, shifterSignFlag, extRdDataA};
        2'h1: obs = {8'h00, dmRdData};
        2'h2: obs = {3'h0, xClass, xSign, xTrueExp, xSignificand};
        default: obs = {8'h00, pmRdData};
      endcase
      n_checks++;
      if ((obs & nt.m) !== (nt.v & nt.m)) begin
        fails++;
        $display("Error at %0t: port %0d got %h expected %h", $time, nt.sel, obs, nt.v);
      end
    end
  end

  // bank is left alone here so that back-to-back shifter checks see one register set
  task automatic loadXY(input logic [39:0] x, input logic [39:0] y);
    extWrEn = 1'b1;
    extWrAddr = 4'h1;
    extWrData = x;
    pmWrEn = 1'b1;
    pmAddr = 4'h4;
    pmWrData = y;
    @(negedge clk);
    extWrEn = 1'b0;
    pmWrEn = 1'b0;
  endtask : loadXY

  task automatic issue(input sfp_op_t op, input logic [3:0] x, input logic [3:0] d);
    opValid = 1'b1;
    opCode = op;
    srcX = x;
    srcY = 4'h4;
    dst = d;
    extRdAddrB = 4'($urandom);
    @(negedge clk);
    extRdAddrA = d;
  endtask : issue

  task automatic opCheck(input sfp_op_t op, input logic [39:0] x, input logic [39:0] y,
                         input logic [47:0] e);
    loadXY(x, y);
    issue(op, 4'h1, 4'h2);
    opValid = 1'b0;
    push(2'h0, e, ALL);
    @(negedge clk);
  endtask : opCheck

  // pack then unpack the packed value on the very next cycle
  task automatic packChain(input logic [31:0] f);
    logic [16:0] p;
    p = packRef(f);
    altBank = 1'($urandom);
    loadXY({f, 8'h00}, 40'h0);
    issue(SFP_OP_FPACK, 4'h1, 4'h2);
    push(2'h0, {5'h00, p[16], 2'h0, 16'h0000, p[15:0], 8'h00}, ALL);
    issue(SFP_OP_FUNPACK, 4'h2, 4'h3);
    opValid = 1'b0;
    push(2'h0, {8'h00, unpackRef(p[15:0]), 8'h00}, ALL);
    @(negedge clk);
  endtask : packChain

  task automatic decodeOne(input logic [31:0] f);
    logic [39:0] d;
    logic [47:0] e;
    d = {f, 8'($urandom)};
    e = decRef(d);
    altBank = 1'($urandom);
    loadXY(d, 40'h0);
    srcX = 4'h1;
    @(negedge clk);
    push(2'h2, e, (e[44:42] == SFP_CL_NORMAL) ? ALL : 48'hFE00_0000_0000);
    @(negedge clk);
  endtask : decodeOne

  task automatic busXfer();
    logic [39:0] a;
    logic [39:0] b;
    a = {$urandom, 8'($urandom)};
    b = {$urandom, 8'($urandom)};
    altBank = 1'($urandom);
    pmWrEn = 1'b1;
    pmAddr = 4'h5;
    pmWrData = a;
    dmWrEn = 1'b1;
    dmAddr = 4'h6;
    dmWrData = b;
    @(negedge clk);
    pmWrEn = 1'b0;
    dmWrEn = 1'b0;
    pmAddr = 4'h6;
    dmAddr = 4'h5;
    @(negedge clk);
    push(2'h1, {8'h00, a}, ALL);
    push(2'h3, {8'h00, b}, ALL);
    @(negedge clk);
  endtask : busXfer

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    {altBank, opValid, extWrEn, pmWrEn, dmWrEn} = 5'h00;
    opCode = SFP_OP_NOP;
    {srcX, srcY, dst, extRdAddrA, extRdAddrB, extWrAddr, pmAddr, dmAddr} = 32'h0;
    {extWrData, pmWrData, dmWrData} = 120'h0;
    void'($urandom(32'h893814CC));
    repeat (6) @(posedge clk);
    @(negedge clk);
    push(2'h0, 48'h0, ALL);
    push(2'h2, {3'h0, SFP_CL_ZERO, 42'h0}, ALL);
    rst_n = 1'b1;
    @(negedge clk);
    $display("test reset done, %0d mismatches", fails);
    for (int i = 0; i < 5; i++) begin
      decodeOne(decF[i]);
    end
    $display("test decode done, %0d mismatches", fails);
    for (int i = 0; i < 8; i++) begin
      packChain(dirF[i]);
    end
    repeat (40) begin
      packChain({1'($urandom), 8'(100 + $urandom % 41), 23'($urandom)});
    end
    $display("test pack chain done, %0d mismatches", fails);
    for (int i = 0; i < 6; i++) begin
      opCheck(SFP_OP_FUNPACK, {16'($urandom), dirH[i], 8'h00}, 40'h0,
              {8'h00, unpackRef(dirH[i]), 8'h00});
    end
    $display("test unpack done, %0d mismatches", fails);
    // shifter ops also drive the flags up, so the later clears are visible
    opCheck(SFP_OP_ASH, 40'h80_0000_0000, 40'h00_0000_FC00, 48'h01_F8_0000_0000);
    opCheck(SFP_OP_LSH, 40'h00_0000_F100, 40'h00_0000_0400, 48'h0000_000F_1000);
    opCheck(SFP_OP_LSH, 40'h80_0000_0000, 40'h00_0000_0100, 48'h06_00_0000_0000);
    opCheck(SFP_OP_NOP, 40'h12_3456_7800, 40'h00_0000_0100, 48'h06_00_0000_0000);
    packChain(32'h3F80_0000);
    $display("test shifter done, %0d mismatches", fails);
    repeat (4) begin
      busXfer();
    end
    $display("test memory ports done, %0d mismatches", fails);
    report_and_stop();
  end
endmodule : tb_top
